// ### core/scfe_device.sv
`timescale 1ns/1ps
`include "scfe_map.svh"

module scfe_device #(
  parameter bit HAS_GPIO = 1'b1
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // serial link
  scfe_if.slave link,
  // adc registers
  output logic [7:0] conv_reg_o,
  output logic [7:0] setup_reg_o,
  output logic [7:0] unipolar_reg_o,
  output logic [7:0] bipolar_reg_o,
  output logic [7:0] avg_reg_o,
  output logic [7:0] reset_reg_o,
  output logic reset_stb_o,
  output logic [1:0] clock_mode_o,
  output logic convert_start_n_en_o,
  output logic ref_or_analog_shared_pin_is_ref_o,
  // dac register
  output logic [15:0] dac_reg_o,
  output logic dac_load_o,
  // gpio registers
  output logic [7:0] gpio_cfg_o,
  output logic [7:0] gpio_out_o,
  input wire logic [7:0] gpio_in_i,
  // conversion result to shift out
  input wire logic [11:0] result_i,
  input wire logic result_bipolar_i,
  input wire logic result_temp_i
);
  import scfe_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] cs_s;
  logic [1:0] sck_s;
  logic [1:0] din_s;
  logic sck_d;
  logic din_d;
  logic cs_act;
  logic sck_fall;
  logic sck_rise;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cs_s <= 2'h3;
      sck_s <= 2'h0;
      din_s <= 2'h0;
      sck_d <= 1'b0;
      din_d <= 1'b0;
    end else begin
      cs_s <= {cs_s[0], link.cs_n};
      sck_s <= {sck_s[0], link.sclk};
      din_s <= {din_s[0], link.mosi};
      sck_d <= sck_s[1];
      // master may change data on the same edge; keep the pre-edge bit
      din_d <= din_s[1];
    end
  end

  assign cs_act = ~cs_s[1];
  assign sck_fall = sck_d & ~sck_s[1];
  assign sck_rise = ~sck_d & sck_s[1];

  ////////////////////////////////////////////////////////////////////////
  // command decode
  function automatic scfe_kind_t decode(input logic [7:0] b);
    scfe_kind_t k;
    k = SCFE_K_NOP;
    if ((b & `SCFE_MSK_CONV) == `SCFE_VAL_CONV) begin
      k = SCFE_K_CONV;
    end else if ((b & `SCFE_MSK_SETUP) == `SCFE_VAL_SETUP) begin
      k = SCFE_K_SETUP;
    end else if ((b & `SCFE_MSK_AVG) == `SCFE_VAL_AVG) begin
      k = SCFE_K_AVG;
    end else if ((b & `SCFE_MSK_DAC) == `SCFE_VAL_DAC) begin
      k = SCFE_K_DAC;
    end else if ((b & `SCFE_MSK_RST) == `SCFE_VAL_RST) begin
      k = SCFE_K_RST;
    end else if (HAS_GPIO && b == `SCFE_CMD_GCFG) begin
      k = SCFE_K_GCFG;
    end else if (HAS_GPIO && b == `SCFE_CMD_GWR) begin
      k = SCFE_K_GWR;
    end else if (HAS_GPIO && b == `SCFE_CMD_GRD) begin
      k = SCFE_K_GRD;
    end
    return k;
  endfunction

  function automatic logic [4:0] length(input scfe_kind_t k, input logic [7:0] b);
    logic [4:0] n;
    n = `SCFE_LEN_1B;
    unique case (k)
      SCFE_K_SETUP: n = b[`SCFE_SETUP_FOLLOW_BIT] ? `SCFE_LEN_2B : `SCFE_LEN_1B;
      SCFE_K_DAC: n = `SCFE_LEN_3B;
      SCFE_K_GCFG, SCFE_K_GWR, SCFE_K_GRD: n = `SCFE_LEN_2B;
      default: n = `SCFE_LEN_1B;
    endcase
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // shared shift-and-decode engine
  scfe_state_t state;
  scfe_kind_t kind;
  logic [4:0] bit_cnt;
  logic [4:0] total;
  logic [7:0] cmd_byte;
  logic [23:0] shreg;
  logic [23:0] next_shreg;
  logic [7:0] next_cmd;
  scfe_kind_t next_kind;
  logic cmd_done;
  logic data_done;

  assign next_shreg = {shreg[22:0], din_d};
  assign next_cmd = next_shreg[7:0];
  assign next_kind = decode(next_cmd);
  // decode only once the eighth bit is in
  assign cmd_done = cs_act && sck_fall && state == SCFE_ST_CMD
    && bit_cnt == `SCFE_CMD_LAST;
  assign data_done = cs_act && sck_fall && state == SCFE_ST_DATA
    && (bit_cnt + 5'h01) == total;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= SCFE_ST_CMD;
      bit_cnt <= 5'h00;
      shreg <= 24'h000000;
      total <= `SCFE_LEN_1B;
    end else if (!cs_act) begin
      state <= SCFE_ST_CMD;
      bit_cnt <= 5'h00;
      shreg <= 24'h000000;
    end else if (sck_fall && state != SCFE_ST_DONE) begin
      shreg <= next_shreg;
      bit_cnt <= bit_cnt + 5'h01;
      if (cmd_done) begin
        total <= length(next_kind, next_cmd);
        state <= (length(next_kind, next_cmd) == `SCFE_LEN_1B) ? SCFE_ST_DONE
          : SCFE_ST_DATA;
      end else if (data_done) begin
        state <= SCFE_ST_DONE;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      kind <= SCFE_K_NOP;
      cmd_byte <= `SCFE_BYTE_RST;
    end else if (cmd_done) begin
      kind <= next_kind;
      cmd_byte <= next_cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // adc registers, written at the end of the byte that carries them
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      conv_reg_o <= `SCFE_BYTE_RST;
      setup_reg_o <= `SCFE_SETUP_RST;
      avg_reg_o <= `SCFE_BYTE_RST;
      reset_reg_o <= `SCFE_BYTE_RST;
      reset_stb_o <= 1'b0;
    end else begin
      reset_stb_o <= 1'b0;
      if (cmd_done) begin
        unique case (next_kind)
          SCFE_K_CONV: conv_reg_o <= next_cmd;
          SCFE_K_SETUP: setup_reg_o <= next_cmd;
          SCFE_K_AVG: avg_reg_o <= next_cmd;
          SCFE_K_RST: begin
            reset_reg_o <= next_cmd;
            reset_stb_o <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      unipolar_reg_o <= `SCFE_BYTE_RST;
      bipolar_reg_o <= `SCFE_BYTE_RST;
    end else if (data_done && kind == SCFE_K_SETUP) begin
      if (cmd_byte[`SCFE_SETUP_BIP_BIT]) begin
        bipolar_reg_o <= next_shreg[7:0];
      end else begin
        unipolar_reg_o <= next_shreg[7:0];
      end
    end
  end

  assign clock_mode_o = setup_reg_o[`SCFE_CKMODE_LSB +: 2];
  // conversion-start input only in the externally timed clock modes
  assign convert_start_n_en_o = clock_mode_o == `SCFE_CKMODE_EXT_A
    || clock_mode_o == `SCFE_CKMODE_EXT_B;
  assign ref_or_analog_shared_pin_is_ref_o =
    setup_reg_o[`SCFE_REF_LSB +: 2] == `SCFE_REF_PIN;

  ////////////////////////////////////////////////////////////////////////
  // dac and gpio registers
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dac_reg_o <= `SCFE_DAC_RST;
      dac_load_o <= 1'b0;
    end else begin
      dac_load_o <= data_done && kind == SCFE_K_DAC;
      if (data_done && kind == SCFE_K_DAC) begin
        dac_reg_o <= next_shreg[15:0];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gpio_cfg_o <= `SCFE_BYTE_RST;
      gpio_out_o <= `SCFE_BYTE_RST;
    end else if (data_done && kind == SCFE_K_GCFG) begin
      gpio_cfg_o <= next_shreg[7:0];
    end else if (data_done && kind == SCFE_K_GWR) begin
      gpio_out_o <= next_shreg[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial output
  function automatic logic [15:0] fmt(input logic [11:0] r, input logic tc);
    logic [15:0] w;
    w = {4'h0, r};
    if (tc) begin
      // offset binary to sign-extended two's complement
      w = {{5{~r[11]}}, r[10:0]};
    end
    return w;
  endfunction

  logic [15:0] out_sh;
  logic out_edge;

  assign out_edge = (clock_mode_o == `SCFE_CKMODE_RISE) ? sck_rise : sck_fall;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_sh <= 16'h0000;
    end else if (!cs_act) begin
      out_sh <= fmt(result_i, result_bipolar_i | result_temp_i);
    end else if (cmd_done && next_kind == SCFE_K_GRD) begin
      out_sh <= {gpio_in_i, 8'h00};
    end else if (out_edge) begin
      out_sh <= {out_sh[14:0], 1'b0};
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      link.miso_oe <= 1'b0;
    end else begin
      link.miso_oe <= cs_act;
    end
  end

  assign link.miso = out_sh[15];
endmodule

// ### core/scfe_host.sv
`timescale 1ns/1ps
`include "scfe_map.svh"

module scfe_host #(
  parameter int HALF_CYC = `SCFE_HALF_CYCLES
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic [1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // serial link
  scfe_if.master link
);
  import scfe_pkg::*;

  scfe_hstate_t state;
  logic [7:0] div_cnt;
  logic tick;
  logic [5:0] edges;
  logic [23:0] tx;
  logic [23:0] rx;
  logic cpol;
  logic [1:0] miso_s;
  logic start;

  assign start = wr_i && addr_i == `SCFE_H_CTRL && state == SCFE_H_IDLE
    && wdata_i[1:0] != 2'h0;

  ////////////////////////////////////////////////////////////////////////
  // divider: one tick per half period of the serial clock
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt <= 8'h00;
      tick <= 1'b0;
    end else if (state == SCFE_H_IDLE || div_cnt == 8'(HALF_CYC - 1)) begin
      div_cnt <= 8'h00;
      tick <= state != SCFE_H_IDLE;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      tick <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      miso_s <= 2'h3;
    end else begin
      miso_s <= {miso_s[0], link.miso_line};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame sequencer
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= SCFE_H_IDLE;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.mosi <= 1'b0;
      edges <= 6'h00;
      tx <= 24'h000000;
      rx <= 24'h000000;
      cpol <= 1'b0;
    end else if (state == SCFE_H_IDLE) begin
      link.sclk <= cpol;
      if (wr_i && addr_i == `SCFE_H_TX) begin
        tx <= wdata_i[23:0];
      end
      if (start) begin
        // cs stays low for all bytes of the frame
        state <= SCFE_H_RUN;
        cpol <= wdata_i[`SCFE_H_CPOL_BIT];
        link.sclk <= wdata_i[`SCFE_H_CPOL_BIT];
        link.cs_n <= 1'b0;
        link.mosi <= tx[23];
        edges <= {wdata_i[1:0], 4'h0};
        rx <= 24'h000000;
      end
    end else if (tick) begin
      if (edges == 6'h00) begin
        link.cs_n <= 1'b1;
        state <= SCFE_H_IDLE;
      end else begin
        // clock made here by division, never faster than 25MHz
        link.sclk <= ~link.sclk;
        edges <= edges - 6'h01;
        if (link.sclk) begin
          rx <= {rx[22:0], miso_s[1]};
          tx <= {tx[22:0], 1'b0};
          link.mosi <= tx[22];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register reads
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      unique case (addr_i)
        `SCFE_H_CTRL: rdata_o <= {29'h00000000, cpol, 2'h0};
        `SCFE_H_TX: rdata_o <= {8'h00, tx};
        `SCFE_H_STAT: rdata_o <= {31'h00000000, state == SCFE_H_RUN};
        `SCFE_H_RX: rdata_o <= {8'h00, rx};
      endcase
    end else begin
      rdata_o <= 32'h00000000;
    end
  end
endmodule

// ### core/scfe_if.sv
`timescale 1ns/1ps
interface scfe_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe;
  wire miso_line;

  // board pull-up holds the line high while the device floats it
  assign miso_line = miso_oe ? miso : 1'b1;

  modport master(output cs_n, output sclk, output mosi, input miso_line);
  modport slave(input cs_n, input sclk, input mosi, output miso, output miso_oe);
endinterface

// ### core/scfe_map.svh
`ifndef SCFE_MAP_SVH
`define SCFE_MAP_SVH

// clocks and serial timing
`define SCFE_MCLK_NS 8
`define SCFE_SCLK_MAX_MHZ 25
`define SCFE_SCLK_HALF_NS 32
`define SCFE_HALF_CYCLES ((`SCFE_SCLK_HALF_NS + `SCFE_MCLK_NS - 1) / `SCFE_MCLK_NS)

// transaction lengths in bits
`define SCFE_LEN_1B 5'h08
`define SCFE_LEN_2B 5'h10
`define SCFE_LEN_3B 5'h18
`define SCFE_CMD_LAST 5'h07

// command byte decode: (byte & mask) == value
`define SCFE_MSK_CONV 8'h80
`define SCFE_VAL_CONV 8'h80
`define SCFE_MSK_SETUP 8'hC0
`define SCFE_VAL_SETUP 8'h40
`define SCFE_MSK_AVG 8'hE0
`define SCFE_VAL_AVG 8'h20
`define SCFE_MSK_DAC 8'hF0
`define SCFE_VAL_DAC 8'h10
`define SCFE_MSK_RST 8'hF8
`define SCFE_VAL_RST 8'h08
`define SCFE_CMD_GCFG 8'h03
`define SCFE_CMD_GWR 8'h02
`define SCFE_CMD_GRD 8'h01

// setup byte fields
`define SCFE_SETUP_FOLLOW_BIT 1
`define SCFE_SETUP_BIP_BIT 0
`define SCFE_CKMODE_LSB 4
`define SCFE_REF_LSB 2
`define SCFE_CKMODE_RISE 2'h3
`define SCFE_CKMODE_EXT_A 2'h1
`define SCFE_CKMODE_EXT_B 2'h2
`define SCFE_REF_PIN 2'h3

// reset values
`define SCFE_SETUP_RST 8'h00
`define SCFE_BYTE_RST 8'h00
`define SCFE_DAC_RST 16'h0000

// host register offsets and fields
`define SCFE_H_CTRL 2'h0
`define SCFE_H_TX 2'h1
`define SCFE_H_STAT 2'h2
`define SCFE_H_RX 2'h3
`define SCFE_H_CPOL_BIT 2

`endif

// ### core/scfe_pkg.sv
package scfe_pkg;
  typedef enum logic [1:0] {
    SCFE_ST_CMD = 2'b00,
    SCFE_ST_DATA = 2'b01,
    SCFE_ST_DONE = 2'b10
  } scfe_state_t;

  typedef enum logic [3:0] {
    SCFE_K_NOP = 4'b0000,
    SCFE_K_CONV = 4'b0001,
    SCFE_K_SETUP = 4'b0010,
    SCFE_K_AVG = 4'b0011,
    SCFE_K_DAC = 4'b0100,
    SCFE_K_RST = 4'b0101,
    SCFE_K_GCFG = 4'b0110,
    SCFE_K_GWR = 4'b0111,
    SCFE_K_GRD = 4'b1000
  } scfe_kind_t;

  typedef enum logic {
    SCFE_H_IDLE = 1'b0,
    SCFE_H_RUN = 1'b1
  } scfe_hstate_t;
endpackage

// ### tb/scfe_chk.sv
`timescale 1ns/1ps
module scfe_chk (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // serial link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic miso_line
);
  logic [5:0] falls;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  // falling clock edges seen inside the current frame
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      falls <= 6'h00;
    end else if (cs_n) begin
      falls <= 6'h00;
    end else if ($fell(sclk)) begin
      falls <= falls + 6'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  a_frame_len: assert property ($rose(cs_n) |-> falls inside {6'h08, 6'h10, 6'h18})
    else $error("frame length is not 8, 16 or 24 bits");
  a_float_idle: assert property (cs_n [*5] |-> !miso_oe)
    else $error("serial output driven while deselected");
  a_oe_release: assert property ($rose(cs_n) |-> ##[1:4] !miso_oe)
    else $error("serial output not released after deselect");
  a_oe_select: assert property ($fell(cs_n) |-> ##[1:6] miso_oe)
    else $error("serial output not driven after select");
  a_line_pullup: assert property (miso_line == (miso_oe ? miso : 1'b1))
    else $error("resolved output line wrong");
  a_sclk_half: assert property ($changed(sclk) |=> $stable(sclk) [*3])
    else $error("serial clock half period too short");
  a_mosi_edge: assert property (!cs_n && $changed(mosi) |-> $changed(sclk) || $fell(cs_n))
    else $error("input data moved away from a clock edge");
  // one output bit per half period at most
  // the reload after deselect may follow the last shift closely
  a_miso_hold: assert property (miso_oe && $past(miso_oe) && $changed(miso) |=>
    (cs_n || $stable(miso)) [*3])
    else $error("serial output changed twice in a half period");
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
`include "scfe_map.svh"
module tb_top;
  import scfe_pkg::*;
  logic mclk_i, reset_n_i, wr_i, rd_i, res_bip, res_tmp, seen_load, seen_rst;
  logic dac_load, rst_stb, cnv_en, is_ref;
  logic [7:0] setup, rreg;
  logic [1:0] addr_i, ckm;
  logic [31:0] wdata_i, rdata_o, rx;
  logic [7:0] gpio_in, conv, uni, bip, avg, gcfg, gout, gout2;
  logic [7:0] tbl [4] = '{8'h70, 8'h6C, 8'h50, 8'h40};
  logic [11:0] res;
  logic [15:0] dac, dac2, exp_res;
  int error_cnt, num_checks;
  int cyc = 0;

  scfe_if lk();
  scfe_if lk2();
  scfe_host scfe_host_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(lk));
  scfe_device scfe_device_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .link(lk),
    .conv_reg_o(conv), .setup_reg_o(setup), .unipolar_reg_o(uni), .bipolar_reg_o(bip),
    .avg_reg_o(avg), .reset_reg_o(rreg), .reset_stb_o(rst_stb), .clock_mode_o(ckm),
    .convert_start_n_en_o(cnv_en), .ref_or_analog_shared_pin_is_ref_o(is_ref),
    .dac_reg_o(dac), .dac_load_o(dac_load), .gpio_cfg_o(gcfg), .gpio_out_o(gout),
    .gpio_in_i(gpio_in), .result_i(res), .result_bipolar_i(res_bip), .result_temp_i(res_tmp));
  // variant without gpio, driven by the bench to break the framing on purpose
  scfe_device #(.HAS_GPIO(1'b0)) scfe_device_2_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .link(lk2), .conv_reg_o(), .setup_reg_o(), .unipolar_reg_o(), .bipolar_reg_o(),
    .avg_reg_o(), .reset_reg_o(), .reset_stb_o(), .clock_mode_o(),
    .convert_start_n_en_o(), .ref_or_analog_shared_pin_is_ref_o(),
    .dac_reg_o(dac2), .dac_load_o(), .gpio_cfg_o(), .gpio_out_o(gout2),
    .gpio_in_i(gpio_in), .result_i(res), .result_bipolar_i(res_bip), .result_temp_i(res_tmp));
  scfe_chk scfe_chk_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .cs_n(lk.cs_n),
    .sclk(lk.sclk), .mosi(lk.mosi), .miso(lk.miso), .miso_oe(lk.miso_oe),
    .miso_line(lk.miso_line));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // gap cycle after each strobe so no strobe is assigned twice in one step
  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic rd(input logic [1:0] a, output logic [31:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(posedge mclk_i);
    d = rdata_o;
  endtask

  task automatic xfer(input logic [1:0] n, input logic cp, input logic [23:0] tx);
    logic [31:0] s;
    s = 32'h1;
    wr(`SCFE_H_TX, {8'h00, tx});
    wr(`SCFE_H_CTRL, {29'h0, cp, n});
    while (s[0] !== 1'b0) rd(`SCFE_H_STAT, s);
    rd(`SCFE_H_RX, rx);
    repeat (8) @(posedge mclk_i);
  endtask

  // bench-made frame on the second link; n below the frame length aborts it
  task automatic bb(input logic [23:0] d, input int n);
    lk2.cs_n <= 1'b0;
    for (int i = 23; i > 23 - n; i--) begin
      lk2.mosi <= d[i];
      repeat (4) @(posedge mclk_i);
      lk2.sclk <= 1'b1;
      repeat (4) @(posedge mclk_i);
      lk2.sclk <= 1'b0;
    end
    repeat (4) @(posedge mclk_i);
    lk2.cs_n <= 1'b1;
    repeat (8) @(posedge mclk_i);
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cyc++;
    if (dac_load === 1'b1) seen_load <= 1'b1;
    if (rst_stb === 1'b1) seen_rst <= 1'b1;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  initial begin
    reset_n_i = 1'b0;
    {wr_i, rd_i, res_bip, res_tmp, seen_load, seen_rst} = 6'h00;
    addr_i = 2'h0;
    wdata_i = 32'h0;
    gpio_in = 8'hC6;
    res = 12'hA53;
    {lk2.cs_n, lk2.sclk, lk2.mosi} = 3'b100;
    error_cnt = 0;
    num_checks = 0;
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    for (int i = 0; i < 3; i++) begin
      res_bip <= (i == 1);
      res_tmp <= (i == 2);
      exp_res = (i == 0) ? {4'h0, res} : {{4{~res[11]}}, ~res[11], res[10:0]};
      xfer(2'h2, 1'b0, {7'h21, (i == 1), 8'hA5 + 8'(i), 8'h00});
      chk("result", {16'h0, exp_res}, rx);
      chk("mode reg", 8'hA5 + 8'(i), (i == 1) ? bip : uni);
    end
    xfer(2'h2, 1'b0, 24'h819000);
    chk("conv extra bits", 8'h81, conv);
    xfer(2'h1, 1'b0, 24'h8C0000);
    chk("conv", 8'h8C, conv);
    xfer(2'h1, 1'b0, 24'h2D0000);
    chk("avg", 8'h2D, avg);
    xfer(2'h1, 1'b0, 24'h0B0000);
    chk("reset strobe", 1, seen_rst);
    chk("reset reg", 8'h0B, rreg);
    for (int i = 0; i < 2; i++) begin
      seen_load = 1'b0;
      xfer(2'h3, 1'b0, {(i == 0) ? 8'h10 : 8'h1F, 8'hC3, 8'(i)});
      chk("dac", {8'hC3, 8'(i)}, dac);
      chk("dac load", 1, seen_load);
    end
    xfer(2'h2, 1'b0, 24'h030F00);
    chk("gpio cfg", 8'h0F, gcfg);
    xfer(2'h2, 1'b0, 24'h025A00);
    chk("gpio out", 8'h5A, gout);
    xfer(2'h2, 1'b0, 24'h010000);
    chk("gpio in", 8'hC6, rx[7:0]);
    // last entry restores mode 00 for the frames that follow
    for (int i = 0; i < 4; i++) begin
      xfer(2'h1, 1'b0, {tbl[i], 16'h0});
      chk("clock mode", tbl[i][5:4], ckm);
      chk("start pin", (tbl[i][5:4] == `SCFE_CKMODE_EXT_A) ||
        (tbl[i][5:4] == `SCFE_CKMODE_EXT_B), cnv_en);
      chk("ref pin", tbl[i][3:2] == `SCFE_REF_PIN, is_ref);
    end
    chk("setup reg", 8'h40, setup);
    xfer(2'h3, 1'b1, 24'h1E1234);
    chk("dac idle high", 16'h1234, dac);
    bb(24'h025A00, 16);
    chk("gpio ignored", 8'h00, gout2);
    bb(24'h10ABCD, 12);
    chk("dac aborted", 16'h0000, dac2);
    bb(24'h10ABCD, 24);
    chk("dac fresh", 16'hABCD, dac2);
    complete_run();
  end
endmodule
